// ==== rtl/bdc_regs.vh ====
`ifndef BDC_REGS_VH
`define BDC_REGS_VH

// ==========================================================
// Clock and timing
// ==========================================================
`define BDC_CLK_KHZ 125000
`define BDC_T_CMD_MIN_MS 500
`define BDC_T_CMD_MAX_MS 4000
`define BDC_T_RST_MIN_MS 5000
`define BDC_T_KEY_HOLD_MS 2000
`define BDC_T_TICK_MS 100
`define BDC_CMD_MIN_CYC (`BDC_CLK_KHZ * `BDC_T_CMD_MIN_MS)
`define BDC_CMD_MAX_CYC (`BDC_CLK_KHZ * `BDC_T_CMD_MAX_MS)
`define BDC_RST_MIN_CYC (`BDC_CLK_KHZ * `BDC_T_RST_MIN_MS)
`define BDC_KEY_HOLD_CYC (`BDC_CLK_KHZ * `BDC_T_KEY_HOLD_MS)
`define BDC_TICK_CYC (`BDC_CLK_KHZ * `BDC_T_TICK_MS)

// ==========================================================
// Register word indices (byte address is four times these)
// ==========================================================
`define BDC_IDX_CTRL 6'h00
`define BDC_IDX_PRESET 6'h01
`define BDC_IDX_CORR 6'h02
`define BDC_IDX_TIMEOUT 6'h03
`define BDC_IDX_REMAIN 6'h04
`define BDC_IDX_STATUS 6'h05
`define BDC_IDX_IRQ_STAT 6'h06
`define BDC_IDX_IRQ_MASK 6'h07

// ==========================================================
// Fields and reset values
// ==========================================================
`define BDC_CTRL_EN_BIT 0
`define BDC_CTRL_UNIT_LSB 4
`define BDC_CTRL_OUTCFG_LSB 8
`define BDC_UNIT_MAX 3'h6
`define BDC_UNIT_RST 3'h1
`define BDC_PRESET_MAX 17'h1869f
`define BDC_PRESET_RST 17'h00000
`define BDC_CORR_RST 18'h00000
`define BDC_TMO_MIN 7'h05
`define BDC_TMO_MAX 7'h64
`define BDC_TMO_RST 7'h05
`define BDC_IRQ_DONE 0
`define BDC_IRQ_TMO 1
`define BDC_IRQ_WARN 2
`define BDC_IRQ_START 3
`define BDC_IRQ_STOP 4
`define BDC_IRQ_W 5

`endif

// ==== rtl/bdc_pulse_meter.v ====
`timescale 1ns/1ps
`default_nettype none

module bdc_pulse_meter
(
  input wire clock,
  input wire resetn,
  input wire sigIn,
  output reg levelOut_r,
  output reg fallPulse_r,
  output reg [31:0] width_r
);

  reg sync1_r;
  reg sync2_r;
  reg sync3_r;
  reg [31:0] count_r;

  // ==========================================================
  // Three-stage synchroniser and width count
  // ==========================================================
  // A level change is accepted only when stages two and three agree, so one
  // sampled glitch cannot start or end a pulse.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      levelOut_r <= 1'b0;
      fallPulse_r <= 1'b0;
      width_r <= 32'h00000000;
      count_r <= 32'h00000000;
    end
    else
    begin
      sync1_r <= sigIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      fallPulse_r <= 1'b0;
      if (sync2_r == sync3_r)
      begin
        levelOut_r <= sync3_r;
        if (levelOut_r && !sync3_r)
        begin
          fallPulse_r <= 1'b1;
          width_r <= count_r;
        end
      end
      if (!levelOut_r)
      begin
        count_r <= 32'h00000000;
      end
      else if (count_r != 32'hffffffff)
      begin
        count_r <= count_r + 32'h00000001;
      end
    end
  end

endmodule // bdc_pulse_meter

`default_nettype wire

// ==== rtl/bdc_dosing_ctrl.v ====
// What this block does
// R1: Dosing enabled fixes pin roles until disabled.
// R2: Pin pulse 0.5-4 s starts when stopped.
// R3: Same pulse window stops a running batch.
// R4: Pin pulse over 5 s or key reloads.
// R5: Start drives output high, count down flow.
// R6: Stop keeps remainder; next start resumes.
// R7: Softkeys act after 2 s hold, release.
// R8: Preset clamps to 9999.9 in tenths.
// R9: Batch ends when counter reaches minus correction.
// R10: Invalid target warns, forces correction to 0.1-preset.
// R11: No flow for timeout raises status.
// R12: Disabling switches both outputs off, frees config.
// R13: Volume unit selects one of seven codes.
// R14: Partner ties unused command pin low.
// R15: Output drops on stop or target reached.
// R16: Out-of-window or disallowed pulses are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "bdc_regs.vh"

module bdc_dosing_ctrl
#(
  parameter [31:0] CMD_MIN_CYC = `BDC_CMD_MIN_CYC,
  parameter [31:0] CMD_MAX_CYC = `BDC_CMD_MAX_CYC,
  parameter [31:0] RST_MIN_CYC = `BDC_RST_MIN_CYC,
  parameter [31:0] KEY_HOLD_CYC = `BDC_KEY_HOLD_CYC,
  parameter [31:0] TICK_CYC = `BDC_TICK_CYC
)
(
  input wire clock,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire command_input_pin,
  input wire keyStart,
  input wire keyStop,
  input wire keyReset,
  input wire flowPulse,
  output reg dosing_output_pin,
  output reg pinsOwned_r,
  output reg irq_r
);

  localparam [1:0] ST_STOP = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  // Merges written bytes into a stored word under the byte enables.
  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] sel;
    integer i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (sel[i])
        begin
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [1:0] state_r;
  reg enable_r;
  reg [2:0] unit_r;
  reg [1:0] outCfg_r;
  reg [16:0] preset_r;
  reg [17:0] corr_r;
  reg [6:0] timeout_r;
  reg [31:0] remain_r;
  reg [4:0] irqStat_r;
  reg [4:0] irqMask_r;
  reg [31:0] tickCnt_r;
  reg [6:0] idleTicks_r;
  reg tmoSeen_r;

  wire [3:0] rawIn;
  wire [3:0] levels;
  wire [3:0] falls;
  wire [127:0] widths;

  assign rawIn = {command_input_pin, keyReset, keyStop, keyStart};

  // ==========================================================
  // Input synchronisers and pulse width meters
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gMeter
      bdc_pulse_meter uMeter
      (
        .clock(clock),
        .resetn(resetn),
        .sigIn(rawIn[g]),
        .levelOut_r(levels[g]),
        .fallPulse_r(falls[g]),
        .width_r(widths[g*32 +: 32])
      );
    end
  endgenerate

  // R7: hold then release
  wire keyStartHit = enable_r && falls[0] && (widths[31:0] >= KEY_HOLD_CYC);
  wire keyStopHit = enable_r && falls[1] && (widths[63:32] >= KEY_HOLD_CYC);
  wire keyResetHit = enable_r && falls[2] && (widths[95:64] >= KEY_HOLD_CYC);
  wire [31:0] pinWidth = widths[127:96];
  // R2: start/stop window
  wire pinShort = enable_r && falls[3] && (pinWidth > CMD_MIN_CYC) && (pinWidth < CMD_MAX_CYC);
  // R4: long reset pulse
  wire pinLong = enable_r && falls[3] && (pinWidth > RST_MIN_CYC);

  // R16: decoded commands only count in their own state
  wire doStart = (state_r == ST_STOP) && (pinShort || keyStartHit);
  // R3: same window stops
  wire doStop = (state_r == ST_RUN) && (pinShort || keyStopHit);
  wire doReload = (state_r != ST_RUN) && (pinLong || keyResetHit);

  wire signed [31:0] corrExt = {{14{corr_r[17]}}, corr_r};
  wire signed [31:0] presetExt = {15'h0000, preset_r};
  wire signed [31:0] remainS = remain_r;
  // R9: end point is minus correction
  wire reached = (remainS + corrExt) <= 32'sd0;
  // R10: target must stay above zero
  wire targetBad = (presetExt + corrExt) <= 32'sd0;
  wire [31:0] forcedCorr = 32'h00000001 - {15'h0000, preset_r};

  wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire busWr = busReq && wb_we_i;
  wire [5:0] regIdx = wb_adr_i[7:2];
  wire inWindow = (wb_adr_i[31:8] == 24'h000000);
  wire [31:0] wrData = wb_dat_i;

  reg [31:0] ctrlWord;
  reg [31:0] ctrlNew;
  reg [31:0] presetNew;
  reg [31:0] tmoNew;
  reg [31:0] rdData;
  reg [4:0] irqSet;

  always @*
  begin
    ctrlWord = 32'h00000000;
    ctrlWord[`BDC_CTRL_EN_BIT] = enable_r;
    ctrlWord[`BDC_CTRL_UNIT_LSB +: 3] = unit_r;
    ctrlWord[`BDC_CTRL_OUTCFG_LSB +: 2] = outCfg_r;
    ctrlNew = mergeBytes(ctrlWord, wrData, wb_sel_i);
    presetNew = mergeBytes({15'h0000, preset_r}, wrData, wb_sel_i);
    tmoNew = mergeBytes({25'h0000000, timeout_r}, wrData, wb_sel_i);
    rdData = 32'h00000000;
    if (inWindow)
    begin
      case (regIdx)
        `BDC_IDX_CTRL: rdData = ctrlWord;
        `BDC_IDX_PRESET: rdData = {15'h0000, preset_r};
        `BDC_IDX_CORR: rdData = corrExt;
        `BDC_IDX_TIMEOUT: rdData = {25'h0000000, timeout_r};
        `BDC_IDX_REMAIN: rdData = remain_r;
        `BDC_IDX_STATUS: rdData = {27'h0000000, tmoSeen_r, pinsOwned_r, dosing_output_pin, state_r};
        `BDC_IDX_IRQ_STAT: rdData = {27'h0000000, irqStat_r};
        `BDC_IDX_IRQ_MASK: rdData = {27'h0000000, irqMask_r};
        default: rdData = 32'h00000000;
      endcase
    end
    irqSet = 5'h00;
    irqSet[`BDC_IRQ_DONE] = (state_r == ST_RUN) && reached;
    irqSet[`BDC_IRQ_TMO] = (state_r == ST_RUN) && !tmoSeen_r && (idleTicks_r >= timeout_r);
    irqSet[`BDC_IRQ_WARN] = targetBad;
    irqSet[`BDC_IRQ_START] = doStart && !reached;
    irqSet[`BDC_IRQ_STOP] = doStop;
  end

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  // Every access, mapped or not, is acknowledged one edge after it is seen;
  // unmapped reads return zero and unmapped writes are dropped.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i)
      begin
        wb_dat_o <= rdData;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  // ==========================================================
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_r <= 1'b0;
      unit_r <= `BDC_UNIT_RST;
      outCfg_r <= 2'h0;
      preset_r <= `BDC_PRESET_RST;
      corr_r <= `BDC_CORR_RST;
      timeout_r <= `BDC_TMO_RST;
      irqMask_r <= 5'h00;
    end
    else
    begin
      if (busWr && inWindow && regIdx == `BDC_IDX_CTRL)
      begin
        enable_r <= ctrlNew[`BDC_CTRL_EN_BIT];
        // R13: only the seven unit codes
        if (ctrlNew[`BDC_CTRL_UNIT_LSB +: 3] <= `BDC_UNIT_MAX)
        begin
          unit_r <= ctrlNew[`BDC_CTRL_UNIT_LSB +: 3];
        end
        // R1: pin roles locked while enabled
        if (!enable_r)
        begin
          outCfg_r <= ctrlNew[`BDC_CTRL_OUTCFG_LSB +: 2];
        end
      end
      // R12: disable leaves both outputs off
      if (enable_r && busWr && inWindow && regIdx == `BDC_IDX_CTRL && !ctrlNew[`BDC_CTRL_EN_BIT])
      begin
        outCfg_r <= 2'h0;
      end
      if (busWr && inWindow && regIdx == `BDC_IDX_PRESET)
      begin
        // R8: clamp to 9999.9
        if (presetNew[31:0] > {15'h0000, `BDC_PRESET_MAX})
        begin
          preset_r <= `BDC_PRESET_MAX;
        end
        else
        begin
          preset_r <= presetNew[16:0];
        end
      end
      if (busWr && inWindow && regIdx == `BDC_IDX_CORR && (&wb_sel_i[2:0]))
      begin
        corr_r <= wrData[17:0];
      end
      // R10: force correction on a bad target
      else if (targetBad)
      begin
        corr_r <= forcedCorr[17:0];
      end
      if (busWr && inWindow && regIdx == `BDC_IDX_TIMEOUT)
      begin
        if (tmoNew[6:0] < `BDC_TMO_MIN)
        begin
          timeout_r <= `BDC_TMO_MIN;
        end
        else if (tmoNew[31:0] > {25'h0000000, `BDC_TMO_MAX})
        begin
          timeout_r <= `BDC_TMO_MAX;
        end
        else
        begin
          timeout_r <= tmoNew[6:0];
        end
      end
      if (busWr && inWindow && regIdx == `BDC_IDX_IRQ_MASK)
      begin
        irqMask_r <= wrData[4:0];
      end
    end
  end

  // ==========================================================
  // Batch sequencer
  // ==========================================================
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_STOP;
      remain_r <= 32'h00000000;
      dosing_output_pin <= 1'b0;
      pinsOwned_r <= 1'b0;
    end
    else
    begin
      // R1: pins owned while enabled
      pinsOwned_r <= enable_r;
      if (!enable_r)
      begin
        // R12: both outputs off
        state_r <= ST_STOP;
        dosing_output_pin <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_STOP:
          begin
            // R6: resume from kept remainder
            if (doStart && !reached)
            begin
              state_r <= ST_RUN;
              // R5: output active on start
              dosing_output_pin <= 1'b1;
            end
            else if (doReload)
            begin
              remain_r <= {15'h0000, preset_r};
            end
          end
          ST_RUN:
          begin
            // R15: output drops on stop or target
            if (doStop)
            begin
              state_r <= ST_STOP;
              dosing_output_pin <= 1'b0;
            end
            else if (reached)
            begin
              state_r <= ST_DONE;
              dosing_output_pin <= 1'b0;
            end
            // R5: count down measured volume
            else if (flowPulse)
            begin
              remain_r <= remain_r - 32'h00000001;
            end
          end
          ST_DONE:
          begin
            // R4: reload after finish
            if (doReload)
            begin
              remain_r <= {15'h0000, preset_r};
              state_r <= ST_STOP;
            end
          end
          default:
          begin
            state_r <= ST_STOP;
            dosing_output_pin <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // No-flow watch and interrupts
  // ==========================================================
  // The idle time is kept in 100 ms ticks so the timeout register compares
  // against a small count instead of a wide cycle figure.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tickCnt_r <= 32'h00000000;
      idleTicks_r <= 7'h00;
      tmoSeen_r <= 1'b0;
      irqStat_r <= 5'h00;
      irq_r <= 1'b0;
    end
    else
    begin
      // R11: timeout on missing flow
      if (state_r != ST_RUN || flowPulse)
      begin
        tickCnt_r <= 32'h00000000;
        idleTicks_r <= 7'h00;
        tmoSeen_r <= 1'b0;
      end
      else
      begin
        if (irqSet[`BDC_IRQ_TMO])
        begin
          tmoSeen_r <= 1'b1;
        end
        if (tickCnt_r >= TICK_CYC - 32'h00000001)
        begin
          tickCnt_r <= 32'h00000000;
          if (idleTicks_r != 7'h7f)
          begin
            idleTicks_r <= idleTicks_r + 7'h01;
          end
        end
        else
        begin
          tickCnt_r <= tickCnt_r + 32'h00000001;
        end
      end
      // A new event in the clearing cycle survives the write-one-to-clear.
      if (busWr && inWindow && regIdx == `BDC_IDX_IRQ_STAT && wb_sel_i[0])
      begin
        irqStat_r <= (irqStat_r & ~wrData[4:0]) | irqSet;
      end
      else
      begin
        irqStat_r <= irqStat_r | irqSet;
      end
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

endmodule // bdc_dosing_ctrl

`default_nettype wire

// ==== tb/bdc_plant_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bdc_plant_model
(
  input wire logic clock,
  input wire logic valveOpen,
  output logic cmdPin,
  output logic flowPulse
);
  initial cmdPin = 1'b0;
  initial flowPulse = 1'b0;
  // ==========================================
  // Command pulses
  // width picks the command
  task automatic pulse(input int w);
    @(posedge clock);
    cmdPin <= 1'b1;
    repeat (w) @(posedge clock);
    cmdPin <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  // ==========================================
  // Flow
  // A leak lets flow pass with the valve shut, to show it is not counted.
  task automatic flow(input int n, input int gap, input logic leak);
    repeat (n)
    begin
      @(posedge clock);
      flowPulse <= valveOpen | leak;
      @(posedge clock);
      flowPulse <= 1'b0;
      repeat (gap) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask
endmodule // bdc_plant_model
`default_nettype wire

// ==== tb/bdc_dosing_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module bdc_dosing_ctrl_sva
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic command_input_pin,
  input wire logic flowPulse,
  input wire logic dosing_output_pin,
  input wire logic pinsOwned_r,
  input wire logic irq_r
);
  logic wrReq;
  assign wrReq = wb_cyc_i & wb_stb_i & wb_we_i;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ==========================================
  // Sequences
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence readReq;
    busReq ##0 !wb_we_i;
  endsequence
  sequence cmdHeld;
    (command_input_pin && !flowPulse)[*8];
  endsequence
  // ==========================================
  // Properties
  ack_on_time_a:
    assert property (busReq |=> wb_ack_o) else $error("ack late");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_from_req_a:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  dat_hold_a:
    assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o)) else $error("read data moved");
  unmapped_zero_a:
    assert property (readReq ##0 (wb_adr_i[31:8] != 24'h0) |=> wb_dat_o == 32'h0) else $error("unmapped not zero");
  start_owned_a:
    assert property ($rose(dosing_output_pin) |-> pinsOwned_r) else $error("dosing without pins");
  start_on_release_a:
    assert property ($rose(dosing_output_pin) |-> !command_input_pin) else $error("start before release");
  pin_steady_a:
    assert property (cmdHeld |-> $stable(dosing_output_pin)) else $error("output moved during pulse");
  drop_on_disable_a:
    assert property ($fell(pinsOwned_r) |-> ##[0:3] !dosing_output_pin) else $error("output kept on disable");
  irq_by_write_a:
    assert property ($fell(irq_r) |-> $past(wrReq) || $past(wrReq, 2) || $past(wrReq, 3)) else $error("irq fell alone");
endmodule // bdc_dosing_ctrl_sva
bind bdc_dosing_ctrl bdc_dosing_ctrl_sva CHK (.clock, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .command_input_pin, .flowPulse, .dosing_output_pin, .pinsOwned_r, .irq_r);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, resetn, cyc, stb, we, cmdPin, flowPulse, ack, dosePin, owned, irq;
  logic [31:0] adr, wdat, rdat, m, v;
  logic [2:0] keys;
  logic [3:0] sel, selNext;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  int n_fail = 0;
  int tests_run = 0;
  int w;
  bdc_dosing_ctrl #(.CMD_MIN_CYC(20), .CMD_MAX_CYC(80), .RST_MIN_CYC(100), .KEY_HOLD_CYC(40), .TICK_CYC(10)) DUT
  (
    .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .command_input_pin(cmdPin),
    .keyStart(keys[0]), .keyStop(keys[1]), .keyReset(keys[2]), .flowPulse(flowPulse),
    .dosing_output_pin(dosePin), .pinsOwned_r(owned), .irq_r(irq)
  );
  bdc_plant_model PLANT (.clock(clock), .valveOpen(dosePin), .cmdPin(cmdPin), .flowPulse(flowPulse));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ==========================================
  // Helpers
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    sel <= selNext;
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] k);
    expQ.push_back(e);
    mskQ.push_back(k);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic key(input logic [2:0] k, input int n);
    @(posedge clock);
    keys <= k;
    repeat (n) @(posedge clock);
    keys <= 3'h0;
    repeat (12) @(posedge clock);
  endtask
  always @(posedge clock)
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1)
    begin
      m = mskQ.pop_front();
      chk(rdat & m, expQ.pop_front() & m);
    end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_sim();
  end
  // ==========================================
  // Scenarios
  initial
  begin
    {cyc, stb, we, resetn, keys, adr, wdat} = '0;
    sel = 4'hf;
    selNext = 4'hf;
    w = $urandom(69);
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(32'h0c, 32'h5, 32'h7f);
    rd(32'h08, 32'h1, 32'hffffffff);
    rd(32'h18, 32'h4, 32'h1f);
    rd(32'h100, 32'h0, 32'hffffffff);
    for (int u = 0; u < 8; u++)
    begin
      wb(1'b1, 32'h0, u << 4);
      rd(32'h0, (u == 7) ? 32'h60 : u << 4, 32'h70);
    end
    wb(1'b1, 32'h04, 32'h1ffff);
    rd(32'h04, 32'h1869f, 32'h1ffff);
    // A random byte lands only in the enabled lane; the merged word is clamped.
    w = $urandom_range(0, 255);
    v = 32'h1009f | (w << 8);
    selNext = 4'h2;
    wb(1'b1, 32'h04, w << 8);
    selNext = 4'hf;
    rd(32'h04, (v > 32'h1869f) ? 32'h1869f : v, 32'h1ffff);
    wb(1'b1, 32'h04, 32'ha);
    wb(1'b1, 32'h18, 32'h1f);
    wb(1'b1, 32'h08, 32'hffffffec);
    rd(32'h08, 32'hfffffff7, 32'hffffffff);
    rd(32'h18, 32'h4, 32'h1f);
    wb(1'b1, 32'h08, 32'hfffffffe);
    // A correction write without all three low byte lanes is dropped.
    selNext = 4'h3;
    wb(1'b1, 32'h08, 32'h5);
    selNext = 4'hf;
    rd(32'h08, 32'hfffffffe, 32'hffffffff);
    wb(1'b1, 32'h18, 32'h1f);
    wb(1'b1, 32'h00, 32'h211);
    rd(32'h14, 32'h8, 32'h1f);
    rd(32'h00, 32'h211, 32'h3f1);
    chk(owned, 1'b1);
    wb(1'b1, 32'h00, 32'h311);
    rd(32'h00, 32'h211, 32'h3f1);
    PLANT.pulse(150);
    rd(32'h10, 32'ha, 32'hffffffff);
    PLANT.pulse($urandom_range(2, 18));
    PLANT.pulse(90);
    key(3'h1, 10);
    rd(32'h14, 32'h8, 32'h1f);
    PLANT.pulse(40);
    rd(32'h14, 32'hd, 32'h1f);
    chk(irq, 1'b0);
    wb(1'b1, 32'h1c, 32'h1f);
    repeat (3) @(posedge clock);
    chk(irq, 1'b1);
    PLANT.flow(3, 2, 1'b0);
    rd(32'h10, 32'h7, 32'hffffffff);
    PLANT.pulse(40);
    chk(dosePin, 1'b0);
    PLANT.flow(2, 1, 1'b1);
    rd(32'h10, 32'h7, 32'hffffffff);
    key(3'h1, 50);
    rd(32'h14, 32'hd, 32'h1f);
    PLANT.flow(5, 3, 1'b0);
    rd(32'h10, 32'h2, 32'hffffffff);
    rd(32'h14, 32'ha, 32'h1f);
    rd(32'h18, 32'h19, 32'h1d);
    // Without byte lane zero the write-one-to-clear is ignored.
    selNext = 4'he;
    wb(1'b1, 32'h18, 32'h1f);
    selNext = 4'hf;
    rd(32'h18, 32'h19, 32'h1d);
    PLANT.pulse(40);
    rd(32'h14, 32'ha, 32'h1f);
    key(3'h4, 50);
    rd(32'h10, 32'ha, 32'hffffffff);
    wb(1'b1, 32'h18, 32'h1f);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    PLANT.pulse(40);
    repeat (80) @(posedge clock);
    rd(32'h18, 32'ha, 32'ha);
    rd(32'h14, 32'h1d, 32'h1f);
    key(3'h2, 50);
    rd(32'h14, 32'h8, 32'h1f);
    wb(1'b1, 32'h00, 32'h10);
    rd(32'h14, 32'h0, 32'hf);
    rd(32'h00, 32'h10, 32'h3f1);
    chk(dosePin, 1'b0);
    chk(owned, 1'b0);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
